// ==== verilog/line_ctrl_pkg.sv ====
package line_ctrl_pkg;

    // register map, word offsets in bytes
    localparam logic [7:0] LINE_CONTROL_OFS = 8'h2C;
    localparam logic [7:0] TX_DATA_OFS      = 8'h00;
    localparam logic [7:0] RX_DATA_OFS      = 8'h04;
    localparam logic [7:0] STATUS_OFS       = 8'h08;

    // line_control field positions
    localparam int BREAK_BIT     = 0;
    localparam int PARITY_EN_BIT = 1;
    localparam int EVEN_PAR_BIT  = 2;
    localparam int TWO_STOP_BIT  = 3;
    localparam int FIFO_EN_BIT   = 4;
    localparam int WORD_LEN_LSB  = 5;
    localparam int STICK_PAR_BIT = 7;

    localparam logic [7:0] LINE_CONTROL_RESET = 8'h00;

    // status bit positions, except that st_word puts overrun at bit 6 and break_det at bit 5
    localparam int ST_TX_FULL   = 0;
    localparam int ST_RX_AVAIL  = 1;
    localparam int ST_TX_BUSY   = 2;
    localparam int ST_PAR_ERR   = 3;
    localparam int ST_FRAME_ERR = 4;
    localparam int ST_OVERRUN   = 5;
    localparam int ST_BREAK_DET = 6;

    // buffers
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW    = 4;

    // bit timing
    localparam int BAUD_DIV_DEFAULT = 1736;
    localparam int DIV_W            = 16;

    typedef struct packed {
        logic       stick_parity_sel;
        logic [1:0] word_length_sel;
        logic       fifo_enable;
        logic       two_stop_sel;
        logic       even_parity_sel;
        logic       parity_enable;
        logic       send_break;
    } line_control_s;

    typedef struct packed {
        logic       parity_err;
        logic       frame_err;
        logic       break_det;
        logic [7:0] data;
    } rx_word_s;

endpackage

// ==== verilog/byte_fifo.sv ====
`timescale 1ns/1ps
module byte_fifo #(
    parameter int W = 8
) (
    input  wire logic         ref_clk_i,
    input  wire logic         nrst_i,
    input  wire logic         flush_i,
    input  wire logic         deep_i,
    input  wire logic         push_i,
    input  wire logic [W-1:0] wdata_i,
    input  wire logic         pop_i,
    output logic [W-1:0]      rdata_o,
    output logic              empty_o,
    output logic              full_o
);
    localparam int AW = line_ctrl_pkg::FIFO_AW;
    localparam int D  = line_ctrl_pkg::FIFO_DEPTH;

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    wire  [AW:0]   cap;
    wire           do_push;
    wire           do_pop;

    // one-byte holding register in character mode
    assign cap     = deep_i ? (AW+1)'(D) : (AW+1)'(1);
    assign empty_o = (cnt_q == '0);
    assign full_o  = (cnt_q >= cap);
    assign do_push = push_i && !full_o;
    assign do_pop  = pop_i && !empty_o;
    assign rdata_o = mem_q[rp_q];

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else if (flush_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) wp_q <= wp_q + AW'(1);
            if (do_pop) rp_q <= rp_q + AW'(1);
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (do_push) mem_q[wp_q] <= wdata_i;
    end
endmodule

// ==== verilog/uart_line_control_framing.sv ====
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
// What this block does
// - word_length_sel 3/2/1/0 selects eight/seven/six/five data bits, five at reset.
// - fifo_enable set buffers both directions in FIFOs; clear uses one-byte holding.
// - two_stop_sel set sends two stop bits, otherwise one.
// - receiver checks only the first stop bit regardless of two_stop_sel.
// - parity enabled with even select gives even count of ones.
// - parity enabled with even select clear gives odd count of ones.
// - even select is ignored while parity is disabled.
// - parity enabled inserts a parity bit on transmit and checks on receive.
// - parity disabled means no parity bit sent or expected.
// - stick parity forces parity bit to zero when even, one when odd.
// - send_break finishes the current character then holds the line low.
module uart_line_control_framing #(
    parameter int BAUD_DIV = line_ctrl_pkg::BAUD_DIV_DEFAULT
) (
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic [31:0]     rdata_o,
    input  wire logic       serial_rx_in_i,
    output logic            serial_tx_out_o
);
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BREAK} tx_state_e;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;

    line_ctrl_pkg::line_control_s lc_q;
    tx_state_e     tx_st_q;
    rx_state_e     rx_st_q;
    logic [31:0]   rdata_q;
    logic          tx_q;
    logic [15:0]   tx_div_q;
    logic [2:0]    tx_bit_q;
    logic          tx_stop2_q;
    logic [7:0]    tx_sh_q;
    logic          tx_par_q;
    logic [15:0]   rx_div_q;
    logic [2:0]    rx_bit_q;
    logic [7:0]    rx_sh_q;
    logic          rx_par_q;
    logic          rx_s1_q;
    logic          rx_s2_q;
    logic          rx_perr_q;
    logic          ovr_q;

    wire           wr_lc    = wr_i && addr_i == line_ctrl_pkg::LINE_CONTROL_OFS;
    wire           wr_tx    = wr_i && addr_i == line_ctrl_pkg::TX_DATA_OFS;
    wire           rd_rx    = rd_i && addr_i == line_ctrl_pkg::RX_DATA_OFS;
    wire           rd_st    = rd_i && addr_i == line_ctrl_pkg::STATUS_OFS;
    // clearing fifo_enable flushes both buffers
    wire           flush    = wr_lc && lc_q.fifo_enable && !wdata_i[line_ctrl_pkg::FIFO_EN_BIT];
    wire [2:0]     last_bit = {1'b1, lc_q.word_length_sel};
    wire [15:0]    div_max  = 16'(BAUD_DIV - 1);
    wire [15:0]    div_half = 16'(BAUD_DIV / 2);
    wire           tx_tick  = (tx_div_q == div_max);
    wire           rx_tick  = (rx_div_q == div_max);
    wire           rx_mid   = (rx_div_q == div_half);

    wire [7:0]     tx_word;
    wire           tx_empty;
    wire           tx_full;
    wire           tx_pop   = (tx_st_q == TX_IDLE) && !tx_empty && !lc_q.send_break;
    line_ctrl_pkg::rx_word_s rx_head;
    line_ctrl_pkg::rx_word_s rx_push_w;
    wire           rx_empty;
    wire           rx_full;
    wire           rx_push  = (rx_st_q == RX_STOP) && rx_mid;
    wire           rx_ferr  = !rx_s2_q;
    wire           rx_break = rx_ferr && rx_sh_q == 8'h00 && !rx_s2_q;

    // masks unused upper bits so short words compute parity correctly
    wire [7:0]     wmask    = 8'hFF >> (3'h7 - last_bit);
    wire           tx_ones  = ^(tx_word & wmask);
    // with stick: even -> 0, odd -> 1
    function automatic logic par_bit(input logic ones, input line_ctrl_pkg::line_control_s c);
        if (c.stick_parity_sel) begin
            par_bit = !c.even_parity_sel;
        end else begin
            par_bit = c.even_parity_sel ? ones : !ones;
        end
    endfunction
    wire           rx_ones  = ^(rx_sh_q & wmask);
    wire           rx_exp   = par_bit(rx_ones, lc_q);

    assign rx_push_w = '{parity_err: rx_perr_q, frame_err: rx_ferr, break_det: rx_break,
                         data: rx_sh_q & wmask};

    byte_fifo #(.W(8)) u_tx_fifo (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .flush_i   (flush),
        .deep_i    (lc_q.fifo_enable),
        .push_i    (wr_tx),
        .wdata_i   (wdata_i[7:0]),
        .pop_i     (tx_pop),
        .rdata_o   (tx_word),
        .empty_o   (tx_empty),
        .full_o    (tx_full)
    );

    byte_fifo #(.W(11)) u_rx_fifo (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .flush_i   (flush),
        .deep_i    (lc_q.fifo_enable),
        .push_i    (rx_push),
        .wdata_i   (rx_push_w),
        .pop_i     (rd_rx),
        .rdata_o   (rx_head),
        .empty_o   (rx_empty),
        .full_o    (rx_full)
    );

    wire [31:0] st_word = {25'h0, ovr_q, rx_head.break_det & !rx_empty, rx_head.frame_err & !rx_empty,
                           rx_head.parity_err & !rx_empty, tx_st_q != TX_IDLE, !rx_empty, tx_full};
    wire [31:0] rd_mux  = (rd_i && addr_i == line_ctrl_pkg::LINE_CONTROL_OFS) ? {24'h0, lc_q} :
                          rd_rx ? {21'h0, rx_empty ? 11'h000 : rx_head} :
                          rd_st ? st_word : 32'h0000_0000;

    // register port
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lc_q    <= line_ctrl_pkg::LINE_CONTROL_RESET;
            rdata_q <= 32'h0000_0000;
            ovr_q   <= 1'b0;
        end else begin
            if (wr_lc) lc_q <= wdata_i[7:0];
            rdata_q <= rd_mux;
            // set wins over clear
            if (rx_push && rx_full) ovr_q <= 1'b1;
            else if (rd_st) ovr_q <= 1'b0;
        end
    end

    // transmitter
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_st_q    <= TX_IDLE;
            tx_q       <= 1'b1;
            tx_div_q   <= 16'h0000;
            tx_bit_q   <= 3'h0;
            tx_stop2_q <= 1'b0;
            tx_sh_q    <= 8'h00;
            tx_par_q   <= 1'b0;
        end else begin
            tx_div_q <= (tx_st_q == TX_IDLE || tx_tick) ? 16'h0000 : tx_div_q + 16'h0001;
            case (tx_st_q)
                TX_IDLE: begin
                    tx_q <= 1'b1;
                    if (lc_q.send_break) begin
                        tx_st_q <= TX_BREAK;
                    end else if (tx_pop) begin
                        tx_sh_q  <= tx_word;
                        tx_par_q <= par_bit(tx_ones, lc_q);
                        tx_q     <= 1'b0;
                        tx_st_q  <= TX_START;
                    end
                end
                TX_START: if (tx_tick) begin
                    tx_q     <= tx_sh_q[0];
                    tx_sh_q  <= tx_sh_q >> 1;
                    tx_bit_q <= 3'h0;
                    tx_st_q  <= TX_DATA;
                end
                TX_DATA: if (tx_tick) begin
                    if (tx_bit_q == last_bit) begin
                        if (lc_q.parity_enable) begin
                            tx_q    <= tx_par_q;
                            tx_st_q <= TX_PAR;
                        end else begin
                            tx_q       <= 1'b1;
                            tx_stop2_q <= lc_q.two_stop_sel;
                            tx_st_q    <= TX_STOP;
                        end
                    end else begin
                        tx_q     <= tx_sh_q[0];
                        tx_sh_q  <= tx_sh_q >> 1;
                        tx_bit_q <= tx_bit_q + 3'h1;
                    end
                end
                TX_PAR: if (tx_tick) begin
                    tx_q       <= 1'b1;
                    tx_stop2_q <= lc_q.two_stop_sel;
                    tx_st_q    <= TX_STOP;
                end
                TX_STOP: if (tx_tick) begin
                    if (tx_stop2_q) begin
                        tx_stop2_q <= 1'b0;
                    end else begin
                        tx_st_q <= lc_q.send_break ? TX_BREAK : TX_IDLE;
                        tx_q    <= !lc_q.send_break;
                    end
                end
                TX_BREAK: begin
                    // software times the break length
                    tx_q <= !lc_q.send_break;
                    if (!lc_q.send_break) tx_st_q <= TX_IDLE;
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // receiver
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_s1_q   <= 1'b1;
            rx_s2_q   <= 1'b1;
            rx_st_q   <= RX_IDLE;
            rx_div_q  <= 16'h0000;
            rx_bit_q  <= 3'h0;
            rx_sh_q   <= 8'h00;
            rx_par_q  <= 1'b0;
            rx_perr_q <= 1'b0;
        end else begin
            rx_s1_q  <= serial_rx_in_i;
            rx_s2_q  <= rx_s1_q;
            rx_div_q <= (rx_st_q == RX_IDLE || rx_tick) ? 16'h0000 : rx_div_q + 16'h0001;
            case (rx_st_q)
                RX_IDLE: if (!rx_s2_q) begin
                    rx_st_q <= RX_START;
                end
                RX_START: if (rx_mid) begin
                    // glitch shorter than half a bit is dropped
                    rx_st_q  <= rx_s2_q ? RX_IDLE : RX_DATA;
                    rx_bit_q <= 3'h0;
                    rx_sh_q  <= 8'h00;
                end
                RX_DATA: if (rx_mid) begin
                    rx_sh_q[rx_bit_q] <= rx_s2_q;
                    if (rx_bit_q == last_bit) begin
                        rx_st_q <= lc_q.parity_enable ? RX_PAR : RX_STOP;
                    end
                    rx_bit_q <= rx_bit_q + 3'h1;
                end
                RX_PAR: if (rx_mid) begin
                    rx_par_q <= rx_s2_q;
                    rx_st_q  <= RX_STOP;
                end
                RX_STOP: if (rx_mid) begin
                    rx_st_q <= RX_IDLE;
                end
                default: rx_st_q <= RX_IDLE;
            endcase
            rx_perr_q <= lc_q.parity_enable && (rx_par_q != rx_exp);
        end
    end

    assign rdata_o         = rdata_q;
    assign serial_tx_out_o = tx_q;
endmodule

// ==== test/uart_line_control_framing_asserts.sv ====
`timescale 1ns/1ps
module uart_line_control_framing_asserts #(
    parameter int BAUD_DIV = 8
) (
    input wire logic        ref_clk_i,
    input wire logic        nrst_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        serial_rx_in_i,
    input wire logic        serial_tx_out_o
);
    logic [15:0] low_q;
    logic [15:0] high_q;
    logic [7:0]  lc_q;
    wire         lc_wr = wr_i && addr_i == line_ctrl_pkg::LINE_CONTROL_OFS;
    wire         lc_rd = rd_i && addr_i == line_ctrl_pkg::LINE_CONTROL_OFS;
    wire         rx_rd = rd_i && addr_i == line_ctrl_pkg::RX_DATA_OFS;
    // run lengths saturate so a long idle never wraps
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            low_q  <= 16'h0000;
            high_q <= 16'hFFFF;
            lc_q   <= 8'h00;
        end else begin
            low_q  <= serial_tx_out_o ? 16'h0000 : low_q + {15'h0000, ~&low_q};
            high_q <= serial_tx_out_o ? high_q + {15'h0000, ~&high_q} : 16'h0000;
            lc_q   <= lc_wr ? wdata_i[7:0] : lc_q;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    a_low_width: assert property ($rose(serial_tx_out_o) |-> low_q >= BAUD_DIV)
        else $error("tx low run too short");
    a_stop_width: assert property ($fell(serial_tx_out_o) |-> high_q >= BAUD_DIV)
        else $error("tx high run too short");
    a_lc_readback: assert property (lc_wr ##1 lc_rd |=> rdata_o == {24'h000000, $past(wdata_i[7:0], 2)})
        else $error("line control readback differs");
    a_lc_reserved: assert property (lc_rd |=> rdata_o[31:8] == 24'h000000)
        else $error("reserved bits not zero");
    a_rx_width: assert property (rx_rd |=> (rdata_o[7:0] >> (4'h5 + {2'h0, $past(lc_q[6:5])})) == 8'h00)
        else $error("rx data wider than word length");
    a_break_hold: assert property (lc_q[0] && low_q > 12 * BAUD_DIV |=> !serial_tx_out_o)
        else $error("break released early");
    a_unmapped_zero: assert property (rd_i && addr_i == 8'h10 |=> rdata_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_rd_quiet: assert property (!$past(rd_i) |-> rdata_o == 32'h00000000)
        else $error("read data outside read slot");
    c_break: cover property (lc_q[0] && low_q > 12 * BAUD_DIV);
    c_two_stop: cover property ($fell(serial_tx_out_o) && lc_q[3]);
    c_lc_read: cover property (lc_wr ##1 lc_rd);
endmodule
bind uart_line_control_framing uart_line_control_framing_asserts #(.BAUD_DIV(BAUD_DIV)) chk_i (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_rx_in_i(serial_rx_in_i),
    .serial_tx_out_o(serial_tx_out_o));

// ==== test/remote_uart.sv ====
`timescale 1ns/1ps
module remote_uart #(
    parameter int BAUD_DIV = 8
) (
    input  wire logic        ref_clk_i,
    input  wire logic        line_i,
    input  wire logic [3:0]  len_i,
    output logic      [11:0] frame_o,
    output logic      [7:0]  seen_o,
    output logic             rx_o
);
    initial begin
        seen_o = 8'h00;
        rx_o   = 1'b1;
    end
    // mid-bit sampling; a break shows as one all-low capture
    always begin
        @(negedge line_i);
        frame_o = 12'hFFF;
        repeat (BAUD_DIV / 2) @(posedge ref_clk_i);
        for (int k = 0; k < len_i; k++) begin
            frame_o[k] = line_i;
            if (k < len_i - 1) repeat (BAUD_DIV) @(posedge ref_clk_i);
        end
        seen_o = seen_o + 8'h01;
    end
    task automatic send(input logic [11:0] bits, input int len);
        for (int k = 0; k < len; k++) begin
            rx_o <= bits[k];
            repeat (BAUD_DIV) @(posedge ref_clk_i);
        end
        rx_o <= 1'b1;
    endtask
endmodule

// ==== test/uart_line_control_framing_tb.sv ====
`timescale 1ns/1ps
module uart_line_control_framing_tb;
    localparam int         BD  = 8;
    localparam logic [7:0] LC  = line_ctrl_pkg::LINE_CONTROL_OFS;
    localparam logic [7:0] TXD = line_ctrl_pkg::TX_DATA_OFS;
    localparam logic [7:0] RXD = line_ctrl_pkg::RX_DATA_OFS;
    logic        ref_clk, nrst, wr, rd, tx, rx;
    logic [7:0]  addr, seen, s0;
    logic [31:0] wdata, rdata, got;
    logic [11:0] fr;
    logic [3:0]  len;
    logic [7:0]  cfg [10] = '{8'h60, 8'h40, 8'h20, 8'h00, 8'h66, 8'h62, 8'h6A, 8'h86, 8'h82, 8'h64};
    int          errors, checks, hi;
    always #2.5 ref_clk = ~ref_clk;
    uart_line_control_framing #(.BAUD_DIV(BD)) uart_line_control_framing_i (
        .ref_clk_i(ref_clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .serial_rx_in_i(rx), .serial_tx_out_o(tx));
    remote_uart #(.BAUD_DIV(BD)) remote_uart_i (
        .ref_clk_i(ref_clk), .line_i(tx), .len_i(len), .frame_o(fr), .seen_o(seen), .rx_o(rx));
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(posedge ref_clk);
        got = rdata;
    endtask
    task automatic idle();
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wait_seen(input logic [7:0] n);
        for (int i = 0; i < 400 && seen != n; i++) @(posedge ref_clk);
    endtask
    function automatic logic [11:0] frame(input logic [7:0] lc, input logic [7:0] d);
        logic [11:0] f;
        int          n;
        logic        p;
        n = 5 + lc[6:5];
        f = 12'hFFE;
        for (int k = 0; k < n; k++) f[k+1] = d[k];
        p = lc[7] ? ~lc[2] : (^(d & ~(8'hFF << n))) ^ ~lc[2];
        if (lc[1]) f[n+1] = p;
        return f;
    endfunction
    // nb bytes written back to back, ne of them expected on the line
    task automatic tx_chk(input logic [7:0] lc, input logic [7:0] d, input int nb, input int ne);
        s0 = seen;
        len <= 4'(7 + lc[6:5] + lc[1] + lc[3]);
        wr_reg(LC, {24'h0, lc});
        for (int k = 0; k < nb; k++) wr_reg(TXD, {24'h0, d + 8'(k)});
        idle();
        for (int k = 0; k < ne; k++) begin
            wait_seen(s0 + 8'(k + 1));
            // a one-deep holding register drops the byte written while it is full
            cmp({20'h0, fr}, {20'h0, frame(lc, d + 8'(k == 0 ? 0 : k + nb - ne))});
        end
        repeat (12 * BD) @(posedge ref_clk);
        cmp({24'h0, seen}, {24'h0, s0 + 8'(ne)});
    endtask
    task automatic rx_chk(input logic [7:0] lc, input logic [11:0] b, input int n, input logic [31:0] e);
        wr_reg(LC, {24'h0, lc});
        idle();
        remote_uart_i.send(b, n);
        repeat (2 * BD) @(posedge ref_clk);
        rd_reg(RXD);
        cmp(got, e);
    endtask
    task automatic give_verdict();
        if (errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        {wr, rd, addr, wdata, len, errors, checks} = '0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rd_reg(LC);
        cmp(got, 32'h0);
        wr_reg(LC, 32'hFFFF_FFFE);
        rd_reg(LC);
        cmp(got, 32'hFE);
        rd_reg(8'h10);
        cmp(got, 32'h0);
        foreach (cfg[i]) tx_chk(cfg[i], 8'hA5 + 8'(i), 1, 1);
        tx_chk(8'h6A, 8'h3C, 3, 2);
        tx_chk(8'h7A, 8'h3C, 3, 3);
        rx_chk(8'h66, frame(8'h66, 8'h3C), 11, 32'h3C);
        rx_chk(8'h66, frame(8'h66, 8'h3C) ^ 12'h200, 11, 32'h43C);
        rx_chk(8'h62, frame(8'h66, 8'h3C), 11, 32'h43C);
        rx_chk(8'h64, frame(8'h60, 8'h3C), 10, 32'h3C);
        rx_chk(8'h60, frame(8'h60, 8'hC3) & 12'hDFF, 10, 32'h2C3);
        rx_chk(8'h68, frame(8'h60, 8'h3C) & 12'hBFF, 11, 32'h3C);
        repeat (12 * BD) @(posedge ref_clk);
        rd_reg(RXD);
        cmp(got, 32'hFF);
        rd_reg(line_ctrl_pkg::STATUS_OFS);
        cmp(got, 32'h0);
        len <= 4'hA;
        s0 = seen;
        wr_reg(LC, 32'h60);
        wr_reg(TXD, 32'h55);
        wr_reg(LC, 32'h61);
        idle();
        wait_seen(s0 + 8'h01);
        cmp({20'h0, fr}, {20'h0, frame(8'h60, 8'h55)});
        repeat (BD) @(posedge ref_clk);
        hi = 0;
        // held over two character periods
        repeat (24 * BD) begin
            @(posedge ref_clk);
            hi += (tx !== 1'b0);
        end
        cmp(32'(hi), 32'h0);
        wr_reg(LC, 32'h60);
        idle();
        repeat (2 * BD) @(posedge ref_clk);
        cmp({31'h0, tx}, 32'h1);
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        give_verdict();
    end
endmodule
